// [muxed_bus_host_interface.sv]
// Host-facing multiplexed address/data port with interrupt daisy chain.
// Assumes all pins synchronous to core_clk_i and strobes held for whole cycles.
//
// Function
// - One eight-line bus carries address and data
// - Address, acknowledge, low select sampled under address strobe
// - Selected when low select low, high select high
// - Data moves during the data strobe
// - Read/write high reads, low writes
// - Both strobes low together resets device
// - Chain out high only if idle, input high
// - Open-drain interrupt request low while requesting and no source under service
// - Acknowledge input marks an acknowledge cycle
// - Registers and request logic use peripheral clock
// - Registers uniquely addressed, readable, writable except status
// - Each source holds pending, service, enable flags
`timescale 1ns/1ps
`default_nettype none
module muxed_bus_host_interface (
  input  wire logic       core_clk_i,              // Peripheral clock
  input  wire logic       sys_rst_i,               // Async reset, active high
  input  wire logic       clk_en_i,                // Freezes all state while low
  input  wire logic [7:0] muxed_addr_data_i,       // Shared bus, input side
  output logic      [7:0] muxed_addr_data_o,       // Shared bus, output side
  output logic            muxed_addr_data_oe_o,    // High while device drives bus
  input  wire logic       addr_latch_strobe_n_i,   // Address strobe, active low
  input  wire logic       xfer_timing_strobe_n_i,  // Data strobe, active low
  input  wire logic       read_not_write_i,        // High read, low write
  input  wire logic       select_low_in_n_i,       // Chip select, active low
  input  wire logic       select_high_in_i,        // Chip select, active high
  input  wire logic       irq_ack_cycle_n_i,       // Acknowledge cycle, active low
  input  wire logic       prio_chain_in_i,         // Daisy chain input
  output logic            prio_chain_out_o,        // Daisy chain output
  output logic            irq_req_n_o,             // Interrupt request level, active low
  output logic            irq_req_oe_o,            // High while request line pulled low
  input  wire logic [3:0] irq_event_i,             // Source events from the peripheral
  output logic            dev_reset_o              // Strobe-reset indication to the core
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {IDLE, ADDR, DATA} phase_t;  // Bus phase states

  phase_t     phase_reg, phase_next;                    // Bus phase
  logic [3:0] addr_reg, addr_next;                      // Latched register index
  logic       sel_reg, sel_next;                        // Latched select
  logic       ack_reg, ack_next;                        // Latched acknowledge
  logic [7:0] regs_q [muxed_bus_pkg::NUM_REGS];         // Register file
  logic [7:0] regs_n [muxed_bus_pkg::NUM_REGS];         // Register file next
  logic [7:0] dout_reg, dout_next;                      // Bus output data
  logic       doe_reg, doe_next;                        // Bus output enable
  logic       ieo_reg, ieo_next;                        // Chain output
  logic       irq_reg, irq_next;                        // Request asserted
  logic       rst_reg, rst_next;                        // Strobe reset flag
  logic       strobe_rst;                               // Both strobes low
  logic       any_req, any_serv;                        // Source summaries

  // Returns true when a source has an enabled pending request and is not under service
  function automatic logic src_req(input logic [7:0] r);
    src_req = r[muxed_bus_pkg::FLD_PEND] & r[muxed_bus_pkg::FLD_ENA] & ~r[muxed_bus_pkg::FLD_SERV];
  endfunction : src_req

  assign strobe_rst = ~addr_latch_strobe_n_i & ~xfer_timing_strobe_n_i;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    phase_next = phase_reg;
    addr_next  = addr_reg;
    sel_next   = sel_reg;
    ack_next   = ack_reg;
    dout_next  = dout_reg;
    doe_next   = 1'b0;
    rst_next   = strobe_rst;
    any_req    = 1'b0;
    any_serv   = 1'b0;
    for (int i = 0; i < muxed_bus_pkg::NUM_REGS; i++) begin
      regs_n[i] = regs_q[i];
    end
    // Hardware events set pending flags; software writes leave them unchanged
    for (int i = 0; i < muxed_bus_pkg::NUM_SRC; i++) begin
      any_req  = any_req | src_req(regs_q[i]);
      any_serv = any_serv | regs_q[i][muxed_bus_pkg::FLD_SERV];
    end
    // Sample index, low select and acknowledge only while the address strobe is low;
    // once the strobe has risen the shared lines already carry write data
    if (!addr_latch_strobe_n_i) begin
      addr_next = muxed_addr_data_i[3:0];
      sel_next  = ~select_low_in_n_i;
      ack_next  = ~irq_ack_cycle_n_i;
    end
    case (phase_reg)
      IDLE: begin
        // Address strobe low opens a transfer
        if (!addr_latch_strobe_n_i) begin
          phase_next = ADDR;
        end
      end
      ADDR: begin
        // Last sample taken under the strobe is held for the data phase
        if (addr_latch_strobe_n_i) begin
          phase_next = DATA;
        end
      end
      default: begin
        // Data phase: transfers only when selected and the data strobe is low
        if (!addr_latch_strobe_n_i) begin
          phase_next = ADDR;
        end else if (!xfer_timing_strobe_n_i && sel_reg && select_high_in_i) begin
          if (ack_reg) begin
            // Acknowledge cycle: the current vector answers
            dout_next = regs_q[muxed_bus_pkg::VEC_IDX];
            doe_next  = prio_chain_in_i;
          end else if (read_not_write_i) begin
            dout_next = regs_q[addr_reg];
            doe_next  = 1'b1;
          end else if (addr_reg < muxed_bus_pkg::CTRL_BASE + 4'(muxed_bus_pkg::NUM_SRC)) begin
            // Control registers: pending flag is status only
            regs_n[addr_reg] = (muxed_addr_data_i & muxed_bus_pkg::CTRL_WMASK)
                             | (regs_q[addr_reg] & ~muxed_bus_pkg::CTRL_WMASK);
          end else begin
            regs_n[addr_reg] = muxed_addr_data_i;
          end
        end
      end
    endcase
    for (int i = 0; i < muxed_bus_pkg::NUM_SRC; i++) begin
      if (irq_event_i[i]) begin
        regs_n[i][muxed_bus_pkg::FLD_PEND] = 1'b1;
      end
    end
    // Acknowledge with chain input high puts every requesting source under service
    if (phase_reg == DATA && ack_reg && prio_chain_in_i && !xfer_timing_strobe_n_i && !doe_reg) begin
      for (int i = 0; i < muxed_bus_pkg::NUM_SRC; i++) begin
        if (src_req(regs_q[i])) begin
          regs_n[i][muxed_bus_pkg::FLD_SERV] = 1'b1;
        end
      end
    end
    // Chain out: idle, and request checked only in acknowledge cycles
    ieo_next = prio_chain_in_i & ~any_serv & ~(ack_reg & any_req);
    irq_next = any_req & ~any_serv;
  end

  // ==========================================================================
  // Registers, clocked from the peripheral clock
  // ==========================================================================
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_reg <= IDLE;
      addr_reg  <= 4'h0;
      sel_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      dout_reg  <= 8'h00;
      doe_reg   <= 1'b0;
      ieo_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      rst_reg   <= 1'b0;
      for (int i = 0; i < muxed_bus_pkg::NUM_REGS; i++) begin
        regs_q[i] <= muxed_bus_pkg::REG_RESET;
      end
    end else if (clk_en_i) begin
      if (strobe_rst) begin
        // Whole-device reset from the illegal strobe combination
        phase_reg <= IDLE;
        addr_reg  <= 4'h0;
        sel_reg   <= 1'b0;
        ack_reg   <= 1'b0;
        dout_reg  <= 8'h00;
        doe_reg   <= 1'b0;
        ieo_reg   <= 1'b0;
        irq_reg   <= 1'b0;
        for (int i = 0; i < muxed_bus_pkg::NUM_REGS; i++) begin
          regs_q[i] <= muxed_bus_pkg::REG_RESET;
        end
      end else begin
        phase_reg <= phase_next;
        addr_reg  <= addr_next;
        sel_reg   <= sel_next;
        ack_reg   <= ack_next;
        dout_reg  <= dout_next;
        doe_reg   <= doe_next;
        ieo_reg   <= ieo_next;
        irq_reg   <= irq_next;
        for (int i = 0; i < muxed_bus_pkg::NUM_REGS; i++) begin
          regs_q[i] <= regs_n[i];
        end
      end
      // Strobe-reset indication follows the strobes, also during that reset
      rst_reg  <= rst_next;
    end
  end

  // Output drive straight from flip-flops; request level tied low
  assign muxed_addr_data_o    = dout_reg;
  assign muxed_addr_data_oe_o = doe_reg;
  assign prio_chain_out_o     = ieo_reg;
  assign irq_req_n_o          = 1'b0;                                   // Open drain: low when driven
  assign irq_req_oe_o         = irq_reg;
  assign dev_reset_o          = rst_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_strobe_reset;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && strobe_rst) |=> (!muxed_addr_data_oe_o && !irq_req_oe_o && dev_reset_o);
  endproperty
  a_strobe_reset: assert property (p_strobe_reset) else $error("strobe reset ignored");

  property p_chain_in_low;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && !prio_chain_in_i && !strobe_rst) |=> !prio_chain_out_o;
  endproperty
  a_chain_in_low: assert property (p_chain_in_low) else $error("chain out high with input low");

  property p_serv_blocks;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && any_serv && !strobe_rst) |=> !prio_chain_out_o;
  endproperty
  a_serv_blocks: assert property (p_serv_blocks) else $error("chain out high under service");

  property p_irq_level;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && !strobe_rst) |=> (irq_req_oe_o == $past(any_req && !any_serv));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("request line wrong");

  property p_no_drive_write;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && !read_not_write_i && !ack_reg) |=> !muxed_addr_data_oe_o;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("bus driven on write");

  property p_drive_needs_ds;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(muxed_addr_data_oe_o) |-> $past(!xfer_timing_strobe_n_i && sel_reg && select_high_in_i);
  endproperty
  a_drive_needs_ds: assert property (p_drive_needs_ds) else $error("bus driven outside strobe");

  property p_addr_hold;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (phase_reg == DATA && addr_latch_strobe_n_i && !strobe_rst) |=> $stable(addr_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address changed in data phase");

  property p_addr_sample;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && !addr_latch_strobe_n_i && !strobe_rst) |=>
        (sel_reg == $past(!select_low_in_n_i) && addr_reg == $past(muxed_addr_data_i[3:0])
         && ack_reg == $past(!irq_ack_cycle_n_i));
  endproperty
  a_addr_sample: assert property (p_addr_sample) else $error("select not sampled");

  property p_event_sets;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && irq_event_i[0] && !strobe_rst) |=> regs_q[0][muxed_bus_pkg::FLD_PEND];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("pending flag not set");

  property p_read_drive;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && phase_reg == DATA && addr_latch_strobe_n_i && !xfer_timing_strobe_n_i && sel_reg
       && select_high_in_i && !ack_reg && read_not_write_i) |=> muxed_addr_data_oe_o;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not answered");

  property p_ack_vector;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && phase_reg == DATA && addr_latch_strobe_n_i && !xfer_timing_strobe_n_i && sel_reg
       && select_high_in_i && ack_reg && prio_chain_in_i)
      |=> (muxed_addr_data_oe_o && muxed_addr_data_o == $past(regs_q[muxed_bus_pkg::VEC_IDX]));
  endproperty
  a_ack_vector: assert property (p_ack_vector) else $error("vector not returned");

  property p_ack_chain_low;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && ack_reg && !prio_chain_in_i) |=> !muxed_addr_data_oe_o;
  endproperty
  a_ack_chain_low: assert property (p_ack_chain_low) else $error("acknowledge answered with chain low");

  property p_unselected;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && !(sel_reg && select_high_in_i)) |=> !muxed_addr_data_oe_o;
  endproperty
  a_unselected: assert property (p_unselected) else $error("bus driven while unselected");

  property p_pend_status;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      $rose(regs_q[0][muxed_bus_pkg::FLD_PEND]) |-> $past(irq_event_i[0]);
  endproperty
  a_pend_status: assert property (p_pend_status) else $error("pending flag written");

  property p_ack_serv;
    @(posedge core_clk_i) disable iff (sys_rst_i)
      (clk_en_i && phase_reg == DATA && ack_reg && prio_chain_in_i && !xfer_timing_strobe_n_i && !doe_reg
       && !strobe_rst && src_req(regs_q[2])) |=> regs_q[2][muxed_bus_pkg::FLD_SERV];
  endproperty
  a_ack_serv: assert property (p_ack_serv) else $error("acknowledged source not under service");

  c_read:  cover property (@(posedge core_clk_i) muxed_addr_data_oe_o && !ack_reg);
  c_ack:   cover property (@(posedge core_clk_i) muxed_addr_data_oe_o && ack_reg);
  c_irq:   cover property (@(posedge core_clk_i) irq_req_oe_o);
  c_sreset: cover property (@(posedge core_clk_i) dev_reset_o);
  c_write:  cover property (@(posedge core_clk_i) phase_reg == DATA && !xfer_timing_strobe_n_i && !read_not_write_i);

endmodule : muxed_bus_host_interface
`default_nettype wire

// [muxed_bus_pkg.sv]
// Constants for the multiplexed host bus interface block.
// Assumes a single 20 MHz core clock; 16 software-visible registers.
package muxed_bus_pkg;
  // ==========================================================================
  // Bus widths and register space
  // ==========================================================================
  localparam int unsigned BUS_W      = 8;            // Shared address/data width
  localparam int unsigned NUM_REGS   = 16;           // Directly addressed registers
  localparam int unsigned ADDR_W     = 4;            // Register index width
  localparam int unsigned NUM_SRC    = 4;            // Interrupt sources
  // ==========================================================================
  // Control register field positions (per interrupt source)
  // ==========================================================================
  localparam int unsigned FLD_PEND   = 5;            // Pending flag, status only
  localparam int unsigned FLD_SERV   = 6;            // Under-service flag
  localparam int unsigned FLD_ENA    = 7;            // Enable flag
  localparam logic [7:0]  CTRL_WMASK = 8'hDF;        // Writable bits of a control register
  localparam logic [3:0]  CTRL_BASE  = 4'h0;         // Control registers start at index 0
  localparam logic [7:0]  REG_RESET  = 8'h00;        // Value of every register after reset
  localparam logic [3:0]  VEC_IDX    = 4'hF;         // Current vector register index
endpackage : muxed_bus_pkg

// [host_cpu_model.sv]
// Host processor model that runs transfers on the shared address/data lines.
// Assumes the device samples every strobe on the rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  input  wire logic       clk_i,        // Bus clock
  input  wire logic [7:0] dev_data_i,   // Device read data
  input  wire logic       dev_oe_i,     // Device drives the lines
  output logic      [7:0] bus_o,        // Resolved shared lines
  output logic            as_n_o,       // Address strobe, active low
  output logic            ds_n_o,       // Data strobe, active low
  output logic            rnw_o,        // High read, low write
  output logic            sel_low_n_o,  // Low select
  output logic            sel_high_o,   // High select
  output logic            ack_n_o       // Acknowledge cycle, active low
);
  logic [7:0] drv;     // Host drive value
  logic       drv_en;  // Host drives the lines
  logic [7:0] last;    // Last resolved bus value
  // ==========================================================================
  // Idle levels and line resolution
  // ==========================================================================
  initial begin
    {as_n_o, ds_n_o, rnw_o, sel_low_n_o, sel_high_o, ack_n_o} = 6'h3D;  // Strobes idle, unselected
    drv    = 8'h00;
    drv_en = 1'b0;
    last   = 8'h00;
  end
  // Released lines show the inverted last value, so no stale copy can pass
  assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv : ~last);
  // Track the last value seen on the lines
  always @(posedge clk_i) begin
    last <= bus_o;
  end
  // ==========================================================================
  // One transfer: address phase, then data phase; oe_seen = {during, after}
  // ==========================================================================
  task automatic xfer(input logic rnw, input logic ack, input logic [1:0] sel, input logic [3:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata, output logic [1:0] oe_seen);
    @(posedge clk_i);
    as_n_o      <= 1'b0;
    ack_n_o     <= ~ack;
    rnw_o       <= rnw;
    sel_low_n_o <= sel[1];
    sel_high_o  <= sel[0];
    drv         <= {4'h0, addr};
    drv_en      <= 1'b1;
    @(posedge clk_i);
    as_n_o      <= 1'b1;
    drv_en      <= ~rnw;             // Write data follows, reads release the lines
    drv         <= wdata;
    @(posedge clk_i);
    ds_n_o      <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    rdata       = bus_o;
    oe_seen[1]  = dev_oe_i;
    @(posedge clk_i);
    ds_n_o      <= 1'b1;
    drv_en      <= 1'b0;
    ack_n_o     <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    oe_seen[0]  = dev_oe_i;
  endtask : xfer
  // Both strobes low together for two edges
  task automatic strobe_reset();
    @(posedge clk_i);
    as_n_o <= 1'b0;
    ds_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    as_n_o <= 1'b1;
    ds_n_o <= 1'b1;
  endtask : strobe_reset
endmodule : host_cpu_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the multiplexed host bus interface.
// Assumes host_cpu_model drives the bus; bench drives chain, events and enables.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic wr; logic [3:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
  logic       clk, rst, clk_en, chain_in, as_n, ds_n, rnw, sel_low_n, sel_high, ack_n;  // Stimulus
  logic       dev_oe, chain_out, irq_n, irq_oe, dev_rst, irq_line, seen;             // Observed
  logic [3:0] irq_event;   // Source events
  logic [7:0] bus, dev_data, rd;
  logic [1:0] oe;          // Drive seen {during, after}
  int         error_cnt;   // Mismatches
  int         checked;     // Comparisons
  int         n;
  row_t       rows [8];    // Ordinary cases
  assign irq_line = irq_oe ? irq_n : 1'b1;  // Pull-up on the request line
  host_cpu_model i_host_cpu_model (.clk_i(clk), .dev_data_i(dev_data), .dev_oe_i(dev_oe), .bus_o(bus),
    .as_n_o(as_n), .ds_n_o(ds_n), .rnw_o(rnw), .sel_low_n_o(sel_low_n), .sel_high_o(sel_high), .ack_n_o(ack_n));
  muxed_bus_host_interface i_muxed_bus_host_interface (.core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(clk_en),
    .muxed_addr_data_i(bus), .muxed_addr_data_o(dev_data), .muxed_addr_data_oe_o(dev_oe),
    .addr_latch_strobe_n_i(as_n), .xfer_timing_strobe_n_i(ds_n), .read_not_write_i(rnw),
    .select_low_in_n_i(sel_low_n), .select_high_in_i(sel_high), .irq_ack_cycle_n_i(ack_n),
    .prio_chain_in_i(chain_in), .prio_chain_out_o(chain_out), .irq_req_n_o(irq_n), .irq_req_oe_o(irq_oe),
    .irq_event_i(irq_event), .dev_reset_o(dev_rst));
  // ==========================================================================
  // Clock, comparison and closing tasks
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One transfer with expected drive pattern and read data
  task automatic rw(input logic r, input logic a, input logic [1:0] s, input logic [3:0] ad,
                    input logic [7:0] wd, input logic [7:0] exp, input logic [1:0] exp_oe);
    i_host_cpu_model.xfer(r, a, s, ad, wd, rd, oe);
    chk("bus_drive", {6'h00, exp_oe}, {6'h00, oe});
    if (exp_oe[1]) chk("read_data", exp, rd);
  endtask : rw
  // Pins: {0, bus drive, chain out, request line, strobe reset}
  task automatic outs(input logic [7:0] exp);
    chk("status_pins", exp, {4'h0, dev_oe, chain_out, irq_line, dev_rst});
  endtask : outs
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #250000;
    error_cnt++;
    end_of_test();
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst = 1'b1; clk_en = 1'b1; chain_in = 1'b1; irq_event = 4'h0; error_cnt = 0; checked = 0; seen = 1'b0;
    rows = '{'{1'b1, 4'h4, 8'hA5, 8'hA5}, '{1'b1, 4'hE, 8'h3C, 8'h3C}, '{1'b1, 4'h1, 8'hFF, 8'hDF},
             '{1'b1, 4'h0, 8'h20, 8'h00}, '{1'b1, 4'hF, 8'h5A, 8'h5A}, '{1'b0, 4'h4, 8'h00, 8'hA5},
             '{1'b0, 4'hE, 8'h00, 8'h3C}, '{1'b1, 4'h1, 8'h00, 8'h00}};
    repeat (5) @(posedge clk);
    @(negedge clk) outs(8'h02);
    @(posedge clk) rst <= 1'b0;
    repeat (2) @(negedge clk);
    outs(8'h06);
    for (n = 0; n < 16; n++) rw(1'b1, 1'b0, 2'b01, n[3:0], 8'h00, 8'h00, 2'b10);
    for (n = 0; n < 8; n++) begin
      if (rows[n].wr) rw(1'b0, 1'b0, 2'b01, rows[n].addr, rows[n].wdata, 8'h00, 2'b00);
      rw(1'b1, 1'b0, 2'b01, rows[n].addr, 8'h00, rows[n].exp, 2'b10);
    end
    // Unselected transfers change nothing and never drive
    rw(1'b0, 1'b0, 2'b00, 4'h4, 8'h11, 8'h00, 2'b00);
    rw(1'b0, 1'b0, 2'b11, 4'h4, 8'h22, 8'h00, 2'b00);
    rw(1'b1, 1'b0, 2'b00, 4'h4, 8'h00, 8'h00, 2'b00);
    rw(1'b1, 1'b0, 2'b01, 4'h4, 8'h00, 8'hA5, 2'b10);
    // Clock enable low freezes the port
    @(posedge clk) clk_en <= 1'b0;
    rw(1'b0, 1'b0, 2'b01, 4'h4, 8'h77, 8'h00, 2'b00);
    @(posedge clk) clk_en <= 1'b1;
    rw(1'b1, 1'b0, 2'b01, 4'h4, 8'h00, 8'hA5, 2'b10);
    // Interrupt request, chain and acknowledge
    rw(1'b0, 1'b0, 2'b01, 4'h2, 8'h80, 8'h00, 2'b00);
    @(posedge clk) irq_event <= 4'h5;
    @(posedge clk) irq_event <= 4'h0;
    repeat (3) @(negedge clk);
    outs(8'h04);
    @(posedge clk) chain_in <= 1'b0;
    repeat (2) @(negedge clk);
    outs(8'h00);
    @(posedge clk) chain_in <= 1'b1;
    rw(1'b1, 1'b0, 2'b01, 4'h2, 8'h00, 8'hA0, 2'b10);
    rw(1'b1, 1'b1, 2'b01, 4'h0, 8'h00, 8'h5A, 2'b10);
    repeat (2) @(negedge clk);
    outs(8'h02);
    i_host_cpu_model.xfer(1'b1, 1'b0, 2'b01, 4'h2, 8'h00, rd, oe);
    chk("ctrl_flags", 8'hC0, rd & 8'hC0);
    rw(1'b0, 1'b0, 2'b01, 4'h2, 8'h00, 8'h00, 2'b00);
    repeat (2) @(negedge clk);
    outs(8'h06);
    @(posedge clk) chain_in <= 1'b0;
    rw(1'b1, 1'b1, 2'b01, 4'h0, 8'h00, 8'h00, 2'b00);
    @(posedge clk) chain_in <= 1'b1;
    // Both strobes low resets the registers
    i_host_cpu_model.strobe_reset();
    for (n = 0; n < 6; n++) @(negedge clk) if (dev_rst === 1'b1) seen = 1'b1;
    chk("strobe_reset", 8'h01, {7'h00, seen});
    rw(1'b1, 1'b0, 2'b01, 4'h4, 8'h00, 8'h00, 2'b10);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
